// >>> rtl/spi_switch_pkg.sv
package spi_switch_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CRC_FRAME_BITS = 32;
	localparam int CRC_BITS = 4;
	localparam logic [3:0] CRC_SEED = 4'hF;
	localparam logic [3:0] CRC_POLY = 4'h3;
	localparam int ADDR_BITS = 6;
	localparam int DATA_BITS = 16;
	localparam int WRITE_BIT_POS = 23;
	localparam int ADDR_LSB = 16;
	localparam int REG_COUNT = 64;
	// switch state register: on bits in [1:0]
	localparam logic [5:0] SWITCH_STATE_ADDR = 6'h01;
	localparam int CH1_ON_POS = 0;
	localparam int CH2_ON_POS = 1;
	// device config: fallback bits and check code enable
	localparam logic [5:0] DEV_CONFIG_ADDR = 6'h02;
	localparam int CH1_FALLBACK_POS = 0;
	localparam int CH2_FALLBACK_POS = 1;
	localparam int CRC_EN_POS = 4;
	// fault summary, read-clear
	localparam logic [5:0] FAULT_SUMMARY_ADDR = 6'h00;
	localparam int COMM_ERR_POS = 0;
	localparam int SCLK_MAX_HZ = 8000000;
	localparam int SYS_CLK_HZ = 200000000;
	localparam int SCLK_HALF_NS = 1000000000 / SCLK_MAX_HZ / 2;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + 4) / 5;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_CONFIG = 3'b001,
		ST_ACTIVE = 3'b011,
		ST_SUPPLY_WARNING = 3'b010,
		ST_AUTO_LOW_POWER_STATE = 3'b110,
		ST_MANUAL_LOW_POWER_STATE = 3'b111,
		ST_FALLBACK = 3'b101,
		ST_SUPPLY_UV = 3'b100
	} dev_state_t;

	function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic b);
		logic fb;
		fb = c[3] ^ b;
		crc4_step = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
	endfunction
endpackage

// >>> rtl/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo_out;
	logic sdo_oe;
	wire sdo_line = sdo_oe ? sdo_out : 1'b1;
	modport primary(output cs_n, output sclk, output sdi, input sdo_line);
	modport secondary(input cs_n, input sclk, input sdi, output sdo_out, output sdo_oe);
endinterface

// >>> rtl/spi_secondary.sv
`timescale 1ns/1ps
// Functional notes
// - software variant active: output follows on bit
// - sleep, config, undervoltage: outputs off
// - software fallback state uses fallback bits
// - software low-power: hold pre-entry on bits
// - pin variant: outputs follow direct inputs
// - pin variant: on bit writes ignored
// - pin low-power: hold pre-entry pin levels
// - serial output released while select high
// - host serial clock at most 8 MHz
// - daisy chain works with or without check
// - host is primary, device secondary
// - select fall: enable output, snapshot faults
// - select rise: commit error-free write
// - select rise: clear read-clear register read
// - host moves select only with clock low
// - sample input on serial clock fall
// - shift output on clock rise
// - host idles serial clock low
// - ignore clock and data while deselected
// - 24-bit frame, data from previous command
// - check code x4+x+1, seed all ones
// - bad length or check: error flag set
module spi_secondary (
	input wire logic sys_clk,
	input wire logic rstn,
	spi_link_if.secondary link,
	input wire logic pin_variant,
	input wire spi_switch_pkg::dev_state_t dev_state,
	input wire logic direct_input_one,
	input wire logic direct_input_two,
	input wire logic [5:0] fault_flags,
	output logic [1:0] channel_out,
	output logic [15:0] switch_state_register,
	output logic [15:0] dev_config_reg,
	output logic comm_err_reg
);
	import spi_switch_pkg::*;

	logic cs_d_reg;
	logic sclk_d_reg;
	logic [31:0] shift_in_reg;
	logic [31:0] shift_out_reg;
	logic [5:0] bit_cnt_reg;
	logic [3:0] crc_reg;
	logic [15:0] read_data_reg;
	logic [15:0] fault_summary_reg;
	logic [1:0] lp_hold_reg;
	logic sdo_reg;
	logic sdo_oe_reg;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic crc_on;
	logic frame_ok;
	logic is_write;
	logic [31:0] rx_frame;
	logic [23:0] reply_hdr;
	logic out_tap;
	logic [5:0] addr;
	logic [15:0] wdata;
	logic [15:0] rd_mux;
	logic [1:0] on_bits;
	logic [1:0] fb_bits;
	logic [1:0] pins;
	logic [1:0] out_next;

	// drop the check byte so fields sit at their plain positions
	function automatic logic [31:0] frame_fields(input logic [31:0] s, input logic on);
		frame_fields = on ? {8'h00, s[31:8]} : s;
	endfunction

	assign cs_fall = cs_d_reg && !link.cs_n;
	assign cs_rise = !cs_d_reg && link.cs_n;
	assign sclk_rise = !link.cs_n && !sclk_d_reg && link.sclk;
	assign sclk_fall = !link.cs_n && sclk_d_reg && !link.sclk;
	assign frame_end = cs_rise && bit_cnt_reg != 6'h00;
	assign crc_on = dev_config_reg[CRC_EN_POS];
	// frame layout: bit 23 write, [21:16] address, [15:0] data; check byte appended
	assign rx_frame = frame_fields(shift_in_reg, crc_on);
	assign is_write = rx_frame[WRITE_BIT_POS];
	assign addr = rx_frame[ADDR_LSB +: ADDR_BITS];
	assign wdata = rx_frame[0 +: DATA_BITS];
	// reply: fault snapshot, then previous data
	assign reply_hdr = {1'b0, comm_err_reg, fault_flags, read_data_reg};
	// tap one frame length down, chained devices see the stream delayed
	assign out_tap = crc_on ? shift_out_reg[CRC_FRAME_BITS - 1] : shift_out_reg[FRAME_BITS - 1];
	assign frame_ok = crc_on ? (bit_cnt_reg == 6'(CRC_FRAME_BITS) && crc_reg == 4'h0)
		: (bit_cnt_reg == 6'(FRAME_BITS));
	assign on_bits = {switch_state_register[CH2_ON_POS], switch_state_register[CH1_ON_POS]};
	assign fb_bits = {dev_config_reg[CH2_FALLBACK_POS], dev_config_reg[CH1_FALLBACK_POS]};
	assign pins = {direct_input_two, direct_input_one};
	assign link.sdo_out = sdo_reg;
	assign link.sdo_oe = sdo_oe_reg;

	// read mux
	always_comb begin
		case (addr)
			SWITCH_STATE_ADDR: rd_mux = switch_state_register;
			DEV_CONFIG_ADDR: rd_mux = dev_config_reg;
			FAULT_SUMMARY_ADDR: rd_mux = fault_summary_reg;
			default: rd_mux = 16'h0000;
		endcase
	end

	// edge detect of select and clock
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cs_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end else begin
			cs_d_reg <= link.cs_n;
			sclk_d_reg <= link.sclk;
		end
	end

	// input shifter, counter and running check code
	always_ff @(posedge sys_clk) begin
		if (!rstn || link.cs_n) begin
			shift_in_reg <= 32'h0;
			bit_cnt_reg <= 6'h00;
			crc_reg <= CRC_SEED;
		end else if (sclk_fall) begin
			shift_in_reg <= {shift_in_reg[30:0], link.sdi};
			if (bit_cnt_reg != 6'h3F) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
			crc_reg <= crc4_step(crc_reg, link.sdi);
		end
	end

	// output shifter: snapshot header plus previous data
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			shift_out_reg <= 32'h0;
			sdo_reg <= 1'b1;
			sdo_oe_reg <= 1'b0;
		end else if (link.cs_n) begin
			sdo_oe_reg <= 1'b0;
			sdo_reg <= 1'b1;
		end else if (cs_fall) begin
			shift_out_reg <= crc_on ? {reply_hdr, 8'h00} : {8'h00, reply_hdr};
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b1;
		end else if (sclk_rise) begin
			sdo_reg <= out_tap;
		end else if (sclk_fall) begin
			shift_out_reg <= {shift_out_reg[30:0], link.sdi};
		end
	end

	// frame end: commit write, capture reply, read-clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			switch_state_register <= 16'h0000;
			dev_config_reg <= 16'h0000;
			read_data_reg <= 16'h0000;
			comm_err_reg <= 1'b0;
			fault_summary_reg <= 16'h0000;
		end else begin
			fault_summary_reg <= fault_summary_reg | {10'h000, fault_flags};
			if (frame_end) begin
				if (!frame_ok) begin
					comm_err_reg <= 1'b1;
				end else if (is_write) begin
					if (addr == SWITCH_STATE_ADDR && !pin_variant) begin
						switch_state_register <= wdata;
					end else if (addr == DEV_CONFIG_ADDR) begin
						dev_config_reg <= wdata;
					end
					read_data_reg <= rd_mux;
				end else begin
					read_data_reg <= rd_mux;
					if (addr == FAULT_SUMMARY_ADDR) begin
						fault_summary_reg <= {10'h000, fault_flags};
						comm_err_reg <= 1'b0;
					end
				end
			end
		end
	end

	// low-power hold capture
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lp_hold_reg <= 2'b00;
		end else if (dev_state != ST_AUTO_LOW_POWER_STATE && dev_state != ST_MANUAL_LOW_POWER_STATE) begin
			lp_hold_reg <= pin_variant ? pins : on_bits;
		end
	end

	// channel output select per state
	always_comb begin
		case (dev_state)
			ST_ACTIVE, ST_SUPPLY_WARNING: out_next = pin_variant ? pins : on_bits;
			ST_FALLBACK: out_next = pin_variant ? pins : fb_bits;
			ST_AUTO_LOW_POWER_STATE, ST_MANUAL_LOW_POWER_STATE: out_next = lp_hold_reg;
			default: out_next = 2'b00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			channel_out <= 2'b00;
		end else begin
			channel_out <= out_next;
		end
	end
endmodule

// >>> rtl/spi_primary.sv
`timescale 1ns/1ps
// host end: runs one frame per start pulse, clock at most 8 MHz
module spi_primary (
	input wire logic sys_clk,
	input wire logic rstn,
	spi_link_if.primary link,
	input wire logic start,
	input wire logic crc_enable,
	input wire logic [23:0] tx_word,
	output logic busy,
	output logic done,
	output logic [31:0] rx_word
);
	import spi_switch_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SETUP = 2'b01,
		H_SHIFT = 2'b11,
		H_END = 2'b10
	} host_state_t;

	host_state_t state_reg;
	logic [31:0] tx_reg;
	logic [5:0] bits_left_reg;
	logic [7:0] div_reg;
	logic cs_n_reg, sclk_reg, sdi_reg;

	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.sdi = sdi_reg;

	// check code over the 24 frame bits, appended in the low byte
	function automatic logic [3:0] frame_crc(input logic [23:0] w);
		logic [3:0] c;
		c = CRC_SEED;
		for (int i = 23; i >= 0; i--) begin
			c = crc4_step(c, w[i]);
		end
		for (int i = 0; i < 4; i++) begin
			c = crc4_step(c, 1'b0);
		end
		frame_crc = c;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_reg <= H_IDLE;
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			sdi_reg <= 1'b0;
			tx_reg <= 32'h0;
			bits_left_reg <= 6'h00;
			div_reg <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			rx_word <= 32'h0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				H_IDLE: begin
					sclk_reg <= 1'b0;
					if (start) begin
						tx_reg <= crc_enable ? {tx_word, 4'h0, frame_crc(tx_word)} : {tx_word, 8'h00};
						bits_left_reg <= crc_enable ? 6'(CRC_FRAME_BITS) : 6'(FRAME_BITS);
						cs_n_reg <= 1'b0;
						busy <= 1'b1;
						div_reg <= 8'h00;
						state_reg <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (div_reg == 8'(SCLK_HALF_CYCLES - 1)) begin
						div_reg <= 8'h00;
						sclk_reg <= 1'b1;
						sdi_reg <= tx_reg[31];
						state_reg <= H_SHIFT;
					end else begin
						div_reg <= div_reg + 8'h01;
					end
				end
				H_SHIFT: begin
					if (div_reg == 8'(SCLK_HALF_CYCLES - 1)) begin
						div_reg <= 8'h00;
						sclk_reg <= !sclk_reg;
						if (sclk_reg) begin
							rx_word <= {rx_word[30:0], link.sdo_line};
							tx_reg <= {tx_reg[30:0], 1'b0};
							bits_left_reg <= bits_left_reg - 6'h01;
							if (bits_left_reg == 6'h01) begin
								state_reg <= H_END;
							end
						end else begin
							sdi_reg <= tx_reg[31];
						end
					end else begin
						div_reg <= div_reg + 8'h01;
					end
				end
				H_END: begin
					if (div_reg == 8'(SCLK_HALF_CYCLES - 1)) begin
						cs_n_reg <= 1'b1;
						busy <= 1'b0;
						done <= 1'b1;
						state_reg <= H_IDLE;
					end else begin
						div_reg <= div_reg + 8'h01;
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end
endmodule

// >>> bench/spi_link_asserts.sv
`timescale 1ns/1ps
module spi_link_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo_out,
	input wire logic sdo_oe
);
	logic sclk_q;
	logic [7:0] lvl;
	logic [5:0] rises;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge sys_clk) sclk_q <= sclk;
	always_ff @(posedge sys_clk) lvl <= (!rstn || sclk != sclk_q) ? 8'h00 : lvl + {7'h00, lvl != 8'hFF};
	always_ff @(posedge sys_clk) rises <= (!rstn || cs_n) ? 6'h00 : rises + {5'h00, sclk && !sclk_q};
	property p_oe_on; $fell(cs_n) |-> ##[1:2] sdo_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("sdo not enabled");
	property p_oe_off; $rose(cs_n) |-> ##[1:2] !sdo_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("sdo not released");
	property p_idle; cs_n && $past(cs_n, 2) |-> !sdo_oe && !sclk; endproperty
	a_idle: assert property (p_idle) else $error("activity while idle");
	property p_cs_edge; $changed(cs_n) |-> !sclk && !$past(sclk); endproperty
	a_cs_edge: assert property (p_cs_edge) else $error("select moved with clock high");
	property p_half; !cs_n && $changed(sclk) |-> lvl >= 8'h0B; endproperty
	a_half: assert property (p_half) else $error("serial clock too fast");
	property p_sdo; !cs_n && !sclk && !$past(sclk, 2) && $past(!cs_n, 4) |-> $stable(sdo_out); endproperty
	a_sdo: assert property (p_sdo) else $error("sdo moved off rising edge");
	property p_len; $rose(cs_n) |-> rises == 6'h18 || rises == 6'h20; endproperty
	a_len: assert property (p_len) else $error("bad frame length");
	property p_sdi; $fell(sclk) |-> $stable(sdi); endproperty
	a_sdi: assert property (p_sdi) else $error("data moved at sample edge");
endmodule

// >>> bench/tb_spi_secondary_output_control.sv
`timescale 1ns/1ps
module tb_spi_secondary_output_control;
	import spi_switch_pkg::*;
	localparam logic [23:0] RD = {2'b00, SWITCH_STATE_ADDR, 16'h0000};
	logic sys_clk = 1'b0, rstn = 1'b0, start = 1'b0, crc_enable = 1'b0, pin_variant = 1'b0;
	logic direct_input_one = 1'b0, direct_input_two = 1'b0, known = 1'b0, err = 1'b0;
	logic [23:0] tx_word = 24'h000000;
	logic [5:0] fault_flags = 6'h00;
	dev_state_t dev_state = ST_SLEEP;
	logic done, busy, comm_err_reg;
	logic [31:0] rx_word;
	logic [1:0] channel_out;
	logic [15:0] switch_state_register, dev_config_reg, prev, sw_m;
	logic [25:0] exq[$];
	logic [25:0] nt;
	int miscompares = 0;
	int checks = 0;
	spi_link_if link();
	always #2.5 sys_clk = ~sys_clk;
	spi_primary u_spi_primary (.sys_clk, .rstn, .link, .start, .crc_enable, .tx_word, .busy, .done, .rx_word);
	spi_secondary u_spi_secondary (.sys_clk, .rstn, .link, .pin_variant, .dev_state, .direct_input_one,
		.direct_input_two, .fault_flags, .channel_out, .switch_state_register, .dev_config_reg, .comm_err_reg);
	spi_link_asserts u_spi_link_asserts (.sys_clk, .rstn, .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
		.sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe));
	function automatic logic [23:0] wr(input logic [15:0] d);
		return {2'b10, SWITCH_STATE_ADDR, d};
	endfunction
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic frame(input logic crc, input logic [23:0] w, input logic bad);
		int n;
		logic [5:0] f;
		f = 6'($urandom());
		fault_flags <= f;
		exq.push_back({known, crc, 1'b0, err, f, prev});
		crc_enable <= crc;
		tx_word <= w;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(posedge sys_clk);
		check("busy", {23'h000000, busy}, 24'h000001);
		for (n = 0; done !== 1'b1; n++) begin
			@(posedge sys_clk);
			if (n > 3000) begin
				miscompares++;
				wrap_up();
			end
		end
		check("idle", {23'h000000, busy}, 24'h000000);
		known = !bad && w[23:16] == RD[23:16];
		prev = sw_m;
		err = bad | (err & w[23:16] != {2'b00, FAULT_SUMMARY_ADDR});
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic out_is(input dev_state_t s, input logic [1:0] e);
		dev_state <= s;
		repeat (4) @(posedge sys_clk);
		check("channel_out", {22'h000000, channel_out}, {22'h000000, e});
	endtask
	always @(posedge sys_clk)
		if (done === 1'b1 && exq.size() > 0) begin
			nt = exq.pop_front();
			if (nt[25])
				check("reply", nt[24] ? rx_word[31:8] : rx_word[23:0], nt[23:0]);
		end
	initial begin
		logic [15:0] d;
		dev_state_t s;
		void'($urandom(95675));
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom());
			frame(1'b0, wr(d), 1'b0);
			sw_m = d;
			frame(1'b0, RD, 1'b0);
			check("sw_reg", {8'h00, switch_state_register}, {8'h00, d});
			out_is(ST_ACTIVE, d[1:0]);
		end
		frame(1'b0, {2'b10, DEV_CONFIG_ADDR, 16'h0002}, 1'b0);
		check("dev_config", {8'h00, dev_config_reg}, 24'h000002);
		out_is(ST_FALLBACK, 2'b10);
		frame(1'b0, wr(16'h0003), 1'b0);
		out_is(ST_SLEEP, 2'b00);
		out_is(ST_CONFIG, 2'b00);
		out_is(ST_SUPPLY_UV, 2'b00);
		for (int k = 1; k < 3; k++) begin
			s = k == 1 ? ST_AUTO_LOW_POWER_STATE : ST_MANUAL_LOW_POWER_STATE;
			frame(1'b0, wr(16'(k)), 1'b0);
			out_is(ST_SUPPLY_WARNING, 2'(k));
			out_is(s, 2'(k));
			frame(1'b0, wr(16'(3 - k)), 1'b0);
			out_is(s, 2'(k));
		end
		pin_variant <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			s = k[0] ? ST_MANUAL_LOW_POWER_STATE : ST_AUTO_LOW_POWER_STATE;
			direct_input_one <= k[0];
			direct_input_two <= k[1];
			out_is(ST_ACTIVE, 2'(k));
			frame(1'b0, wr(16'(~k)), 1'b0);
			out_is(ST_SUPPLY_WARNING, 2'(k));
			out_is(s, 2'(k));
			direct_input_one <= ~k[0];
			direct_input_two <= ~k[1];
			out_is(s, 2'(k));
			out_is(ST_SLEEP, 2'b00);
		end
		pin_variant <= 1'b0;
		dev_state <= ST_ACTIVE;
		d = 16'($urandom());
		frame(1'b0, wr(d), 1'b0);
		sw_m = d;
		frame(1'b1, wr(~d), 1'b1);
		check("chain", {16'h0000, rx_word[7:0]}, {16'h0000, 2'b10, SWITCH_STATE_ADDR});
		check("refused", {7'h00, comm_err_reg, switch_state_register}, {8'h01, d});
		frame(1'b0, {2'b00, FAULT_SUMMARY_ADDR, 16'h0000}, 1'b0);
		check("cleared", {23'h000000, comm_err_reg}, 24'h000000);
		frame(1'b0, {2'b10, DEV_CONFIG_ADDR, 16'h0010}, 1'b0);
		check("crc_config", {8'h00, dev_config_reg}, 24'h000010);
		frame(1'b1, wr(~d), 1'b0);
		sw_m = ~d;
		frame(1'b1, RD, 1'b0);
		frame(1'b1, RD, 1'b0);
		frame(1'b0, wr(d), 1'b1);
		check("crc_refused", {7'h00, comm_err_reg, switch_state_register}, {8'h01, ~d});
		wrap_up();
	end
endmodule
